// ### common/seq_pkg.sv
package seq_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned START_DELAY_US = 41;
  localparam int unsigned EXT_DELAY_MS = 2;
  localparam int unsigned RESET_DELAY_MS = 20;
  localparam int unsigned RESTART_DELAY_MS = 100;
  localparam int unsigned START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
  localparam int unsigned EXT_DELAY_CYC = EXT_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned RESTART_DELAY_CYC = RESTART_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 24;

  localparam logic [6:0] I2C_ADDR = 7'h25;
  localparam logic [7:0] I2C_WRITE_BYTE = 8'h4a;
  localparam logic [7:0] I2C_READ_BYTE = 8'h4b;

  localparam int unsigned RAIL_N = 5;
  localparam int unsigned R_LDO2 = 0;
  localparam int unsigned R_BUCK2 = 1;
  localparam int unsigned R_BUCK1 = 2;
  localparam int unsigned R_BUCK3 = 3;
  localparam int unsigned R_LDO1 = 4;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_ID = 8'h10;
  // Identification value; the value is arbitrary.
  localparam logic [31:0] ID_VALUE = 32'h0000_5e01;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_UP = 1;
  localparam int unsigned EV_SLEEP = 2;
  localparam int unsigned EV_WARN = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP, ST_ACTIVE, ST_DEEP_SLEEP, ST_FAULT
  } seq_state_e;

  typedef struct packed {
    logic [RAIL_N-1:0] enable;
    logic              buck1_alternate;
    logic              buck2_alternate;
    logic              buck3_alternate;
  } rail_ctrl_s;

endpackage : seq_pkg

// ### design/delay_timer.sv
`timescale 1ns/10ps
module delay_timer #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Gate and result.
  input  wire logic gate,
  output logic      done
);

  logic [seq_pkg::CNT_W-1:0] count_reg;
  wire  at_limit = (count_reg >= seq_pkg::CNT_W'(LIMIT - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
      done      <= 1'b0;
    end else if (ce) begin
      if (!gate) begin
        count_reg <= '0;
        done      <= 1'b0;
      end else if (at_limit) begin
        done <= 1'b1;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

endmodule : delay_timer

// ### design/power_sequencer.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module power_sequencer #(
  parameter int unsigned EXT_DELAY_CYC     = seq_pkg::EXT_DELAY_CYC,
  parameter int unsigned RESET_DELAY_CYC   = seq_pkg::RESET_DELAY_CYC,
  parameter int unsigned RESTART_DELAY_CYC = seq_pkg::RESTART_DELAY_CYC
) (
  // Clock, reset and enable.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  // AXI4-Lite write address.
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Analogue status.
  input  wire logic                      input_lockout_release,
  input  wire logic                      input_below_warning,
  input  wire logic [seq_pkg::RAIL_N-1:0] rail_current_limit,
  input  wire logic [seq_pkg::RAIL_N-1:0] rail_undervoltage,
  // Host pins.
  input  wire logic                      deep_sleep_request_pin,
  input  wire logic                      buck1_voltage_select_pin,
  input  wire logic                      buck3_voltage_select_pin,
  // Rail control.
  output seq_pkg::rail_ctrl_s            rail_ctrl,
  output logic [seq_pkg::RAIL_N-1:0]     power_good,
  output logic                           external_supply_enable,
  output logic                           deep_sleep_mode,
  output logic                           undervoltage_fault_state,
  output logic                           irq,
  // Open-drain pins.
  output logic                           supply_warning_out_n_o,
  output logic                           supply_warning_out_n_oe,
  output logic                           interrupt_out_n_o,
  output logic                           interrupt_out_n_oe,
  output logic                           system_reset_out_n_o,
  output logic                           system_reset_out_n_oe
);

  seq_pkg::seq_state_e               state_reg;
  logic [seq_pkg::RAIL_N-1:0]        en_reg;
  logic                              external_supply_enable_reg;
  logic [seq_pkg::EV_W-1:0]          status_reg;
  logic [seq_pkg::EV_W-1:0]          mask_reg;
  logic                              restart_req_reg;
  logic                              warn_seen_reg;
  logic [7:0]                        awaddr_reg;
  logic [31:0]                       wdata_reg;
  logic [3:0]                        wstrb_reg;
  logic                              aw_have_reg;
  logic                              w_have_reg;

  // Good indication and gating for each rail.
  wire [seq_pkg::RAIL_N-1:0] good_now = en_reg & ~rail_current_limit;
  wire [seq_pkg::RAIL_N-1:0] trigger;
  wire [seq_pkg::RAIL_N-1:0] start_done;
  wire ramp_or_run = (state_reg == seq_pkg::ST_RAMP) || (state_reg == seq_pkg::ST_ACTIVE);
  assign trigger[seq_pkg::R_LDO2]  = input_lockout_release && ramp_or_run;
  assign trigger[seq_pkg::R_BUCK2] = good_now[seq_pkg::R_LDO2] && ramp_or_run;
  assign trigger[seq_pkg::R_BUCK1] = good_now[seq_pkg::R_BUCK2] && ramp_or_run;
  assign trigger[seq_pkg::R_BUCK3] = good_now[seq_pkg::R_BUCK1] && ramp_or_run;
  assign trigger[seq_pkg::R_LDO1]  = good_now[seq_pkg::R_BUCK3] && ramp_or_run;

  genvar g;
  generate
    for (g = 0; g < seq_pkg::RAIL_N; g++) begin : g_start
      delay_timer #(.LIMIT(seq_pkg::START_DELAY_CYC)) u_start (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .gate    (trigger[g]),
        .done    (start_done[g])
      );
    end
  endgenerate

  wire ext_done;
  wire rst_done;
  wire restart_done;
  delay_timer #(.LIMIT(EXT_DELAY_CYC)) u_ext (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .gate    (good_now[seq_pkg::R_BUCK3] && ramp_or_run),
    .done    (ext_done)
  );
  delay_timer #(.LIMIT(RESET_DELAY_CYC)) u_rst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .gate    (good_now[seq_pkg::R_LDO1]),
    .done    (rst_done)
  );
  delay_timer #(.LIMIT(RESTART_DELAY_CYC)) u_restart (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .gate    (state_reg == seq_pkg::ST_FAULT),
    .done    (restart_done)
  );

  // Fault and mode decode.
  wire fault_hit  = |(rail_undervoltage & rail_current_limit & en_reg);
  wire all_up     = &en_reg;
  wire sleep_req  = !deep_sleep_request_pin;

  // Register bus decode.
  wire wr_fire    = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire rd_fire    = s_axi_arvalid && s_axi_arready;
  wire wr_mask    = wr_fire && (awaddr_reg == seq_pkg::ADDR_MASK);
  wire wr_ctrl    = wr_fire && (awaddr_reg == seq_pkg::ADDR_CTRL);
  wire wr_known   = wr_mask || wr_ctrl;
  wire rd_status  = rd_fire && (s_axi_araddr == seq_pkg::ADDR_STATUS);
  wire rd_known   = rd_status || (s_axi_araddr == seq_pkg::ADDR_MASK) ||
                    (s_axi_araddr == seq_pkg::ADDR_STATE) ||
                    (s_axi_araddr == seq_pkg::ADDR_CTRL) || (s_axi_araddr == seq_pkg::ADDR_ID);
  wire [31:0] rd_value =
    (s_axi_araddr == seq_pkg::ADDR_STATUS) ? {28'h0, status_reg} :
    (s_axi_araddr == seq_pkg::ADDR_MASK)   ? {28'h0, mask_reg} :
    (s_axi_araddr == seq_pkg::ADDR_STATE)  ? {22'h0, external_supply_enable_reg, en_reg, 1'b0, state_reg} :
    (s_axi_araddr == seq_pkg::ADDR_CTRL)   ? {31'h0, restart_req_reg} :
    (s_axi_araddr == seq_pkg::ADDR_ID)     ? seq_pkg::ID_VALUE : 32'h0;

  // Events; a new event wins over a read clear.
  wire [seq_pkg::EV_W-1:0] ev;
  assign ev[seq_pkg::EV_FAULT] = fault_hit && (state_reg != seq_pkg::ST_FAULT);
  assign ev[seq_pkg::EV_UP]    = (state_reg == seq_pkg::ST_RAMP) && all_up && external_supply_enable_reg;
  assign ev[seq_pkg::EV_SLEEP] = (state_reg == seq_pkg::ST_ACTIVE) && sleep_req;
  assign ev[seq_pkg::EV_WARN]  = input_below_warning && !warn_seen_reg;
  wire [seq_pkg::EV_W-1:0] status_next = (rd_status ? '0 : status_reg) | ev;

  // Next state of the sequencer.
  seq_pkg::seq_state_e state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      seq_pkg::ST_OFF:        if (input_lockout_release) state_next = seq_pkg::ST_RAMP;
      seq_pkg::ST_RAMP:       if (all_up && external_supply_enable_reg) state_next = seq_pkg::ST_ACTIVE;
      seq_pkg::ST_ACTIVE:     if (sleep_req) state_next = seq_pkg::ST_DEEP_SLEEP;
      seq_pkg::ST_DEEP_SLEEP: if (!sleep_req) state_next = seq_pkg::ST_RAMP;
      seq_pkg::ST_FAULT:      if (restart_done) state_next = seq_pkg::ST_OFF;
    endcase
    if (ev[seq_pkg::EV_FAULT] || (restart_req_reg && state_reg != seq_pkg::ST_FAULT)) begin
      state_next = seq_pkg::ST_FAULT;
    end
  end

  // Rail enables: each rail latches on when its start delay ends.
  logic [seq_pkg::RAIL_N-1:0] en_next;
  logic                       ext_next;
  always_comb begin
    en_next  = en_reg | (ramp_or_run ? start_done : '0);
    ext_next = external_supply_enable_reg | (ramp_or_run && ext_done && start_done[seq_pkg::R_LDO1]);
    if (state_next == seq_pkg::ST_DEEP_SLEEP) begin
      en_next  = en_reg & ((seq_pkg::RAIL_N'(1) << seq_pkg::R_LDO2) |
                           (seq_pkg::RAIL_N'(1) << seq_pkg::R_BUCK2));
      ext_next = 1'b0;
    end
    if (state_next == seq_pkg::ST_FAULT || state_next == seq_pkg::ST_OFF) begin
      en_next  = '0;
      ext_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg       <= seq_pkg::ST_OFF;
      en_reg          <= '0;
      external_supply_enable_reg      <= 1'b0;
      status_reg      <= '0;
      mask_reg        <= seq_pkg::MASK_RESET;
      restart_req_reg <= 1'b0;
      warn_seen_reg   <= 1'b0;
    end else if (ce) begin
      state_reg       <= state_next;
      en_reg          <= en_next;
      external_supply_enable_reg      <= ext_next;
      status_reg      <= status_next;
      warn_seen_reg   <= input_below_warning;
      if (wr_mask && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[seq_pkg::EV_W-1:0];
      end
      if (wr_ctrl && wstrb_reg[0]) begin
        restart_req_reg <= wdata_reg[0];
      end else if (state_reg == seq_pkg::ST_FAULT) begin
        restart_req_reg <= 1'b0;
      end
    end
  end

  // Pin-facing registered outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail_ctrl                <= '0;
      power_good               <= '0;
      external_supply_enable   <= 1'b0;
      deep_sleep_mode          <= 1'b0;
      undervoltage_fault_state <= 1'b0;
      irq                      <= 1'b0;
      supply_warning_out_n_o   <= 1'b0;
      supply_warning_out_n_oe  <= 1'b0;
      interrupt_out_n_o        <= 1'b0;
      interrupt_out_n_oe       <= 1'b0;
      system_reset_out_n_o     <= 1'b0;
      system_reset_out_n_oe    <= 1'b1;
    end else if (ce) begin
      rail_ctrl.enable          <= en_next;
      rail_ctrl.buck1_alternate <= !buck1_voltage_select_pin;
      rail_ctrl.buck3_alternate <= !buck3_voltage_select_pin;
      rail_ctrl.buck2_alternate <= (state_next == seq_pkg::ST_DEEP_SLEEP);
      power_good                <= en_next & ~rail_current_limit;
      external_supply_enable    <= ext_next;
      deep_sleep_mode           <= (state_next == seq_pkg::ST_DEEP_SLEEP);
      undervoltage_fault_state  <= (state_next == seq_pkg::ST_FAULT);
      irq                       <= |(status_next & mask_reg);
      supply_warning_out_n_o    <= 1'b0;
      supply_warning_out_n_oe   <= input_below_warning;
      interrupt_out_n_o         <= 1'b0;
      interrupt_out_n_oe        <= (state_next == seq_pkg::ST_FAULT) || |(status_next & mask_reg);
      system_reset_out_n_o      <= 1'b0;
      system_reset_out_n_oe     <= !(rst_done && good_now[seq_pkg::R_LDO1]);
    end
  end

  // AXI4-Lite slave; address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= seq_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= seq_pkg::RESP_OKAY;
      s_axi_rdata   <= '0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
    end else if (ce) begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_known ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : power_sequencer

// ### test/seq_properties.sv
`timescale 1ns/10ps
module seq_properties #(
  parameter int unsigned EXT_DELAY_CYC   = 50,
  parameter int unsigned RESET_DELAY_CYC = 80
) (
  // Clock and reset.
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Inputs seen.
  input wire logic                       input_below_warning,
  input wire logic                       buck1_voltage_select_pin,
  input wire logic                       buck3_voltage_select_pin,
  // Outputs watched.
  input wire seq_pkg::rail_ctrl_s        rail_ctrl,
  input wire logic [seq_pkg::RAIL_N-1:0] power_good,
  input wire logic                       external_supply_enable,
  input wire logic                       deep_sleep_mode,
  input wire logic                       undervoltage_fault_state,
  input wire logic                       supply_warning_out_n_o,
  input wire logic                       supply_warning_out_n_oe,
  input wire logic                       interrupt_out_n_o,
  input wire logic                       interrupt_out_n_oe,
  input wire logic                       system_reset_out_n_o,
  input wire logic                       system_reset_out_n_oe
);
  // Cycles for which each rail has been good without a break.
  logic [12:0] held [seq_pkg::RAIL_N];
  always_ff @(posedge aclk) begin
    for (int i = 0; i < seq_pkg::RAIL_N; i++) begin
      if (!aresetn || !power_good[i]) held[i] <= 13'h0000;
      else if (held[i] != 13'h1fff) held[i] <= held[i] + 13'h0001;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence fault_entry;
    $rose(undervoltage_fault_state);
  endsequence
  sequence all_off;
    rail_ctrl.enable == 5'h00 && !external_supply_enable && interrupt_out_n_oe;
  endsequence
  chk_buck2_delay: assert property ($rose(rail_ctrl.enable[seq_pkg::R_BUCK2])
    |-> held[seq_pkg::R_LDO2] >= seq_pkg::START_DELAY_CYC) else $error("Buck2 enabled early.");
  chk_ldo1_delay: assert property ($rose(rail_ctrl.enable[seq_pkg::R_LDO1])
    |-> held[seq_pkg::R_BUCK3] >= seq_pkg::START_DELAY_CYC) else $error("LDO1 enabled early.");
  chk_sleep_rails: assert property (deep_sleep_mode [*3] |-> (rail_ctrl.enable & 5'h1c) == 5'h00
    && rail_ctrl.enable[1:0] == 2'h3 && !external_supply_enable && rail_ctrl.buck2_alternate)
    else $error("Wrong rails in deep sleep.");
  chk_buck2_alt: assert property (rail_ctrl.buck2_alternate
    |-> deep_sleep_mode || $past(deep_sleep_mode)) else $error("Buck2 lowered outside sleep.");
  chk_buck1_sel: assert property (rail_ctrl.enable[seq_pkg::R_BUCK1]
    |-> rail_ctrl.buck1_alternate == !buck1_voltage_select_pin) else $error("Buck1 setting.");
  chk_buck3_sel: assert property (rail_ctrl.enable[seq_pkg::R_BUCK3]
    |-> rail_ctrl.buck3_alternate == !buck3_voltage_select_pin) else $error("Buck3 setting.");
  chk_warn_pin: assert property (input_below_warning [*3] |-> supply_warning_out_n_oe)
    else $error("Warning pin not pulled.");
  chk_od_low: assert property (supply_warning_out_n_o == 1'b0 && interrupt_out_n_o == 1'b0
    && system_reset_out_n_o == 1'b0) else $error("Open-drain pin driven high.");
  chk_ext_delay: assert property ($rose(external_supply_enable)
    |-> held[seq_pkg::R_BUCK3] >= EXT_DELAY_CYC) else $error("External enable early.");
  chk_reset_delay: assert property ($fell(system_reset_out_n_oe)
    |-> held[seq_pkg::R_LDO1] >= RESET_DELAY_CYC) else $error("Reset released early.");
  chk_fault_off: assert property (fault_entry |-> ##[0:2] all_off)
    else $error("Fault did not shut down.");
endmodule : seq_properties

bind power_sequencer seq_properties #(
  .EXT_DELAY_CYC(EXT_DELAY_CYC), .RESET_DELAY_CYC(RESET_DELAY_CYC)
) seq_properties_inst (
  .aclk, .aresetn, .input_below_warning, .buck1_voltage_select_pin, .buck3_voltage_select_pin,
  .rail_ctrl, .power_good, .external_supply_enable, .deep_sleep_mode, .undervoltage_fault_state,
  .supply_warning_out_n_o, .supply_warning_out_n_oe, .interrupt_out_n_o, .interrupt_out_n_oe,
  .system_reset_out_n_o, .system_reset_out_n_oe
);

// ### test/host_pin_model.sv
`timescale 1ns/10ps
module host_pin_model (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Requests from the bench.
  input  wire logic       sleep_req,
  input  wire logic       sel1_req,
  input  wire logic       sel3_req,
  input  wire logic [4:0] rail_enable,
  // Pins towards the device.
  output logic            deep_sleep_request_pin   = 1'b1,
  output logic            buck1_voltage_select_pin = 1'b1,
  output logic            buck3_voltage_select_pin = 1'b1
);
  // A select pin only moves while its rail is off.
  always @(posedge aclk) begin
    if (!aresetn) deep_sleep_request_pin <= 1'b1;
    else deep_sleep_request_pin <= !sleep_req;
    if (rail_enable[seq_pkg::R_BUCK1] !== 1'b1) buck1_voltage_select_pin <= sel1_req;
    if (rail_enable[seq_pkg::R_BUCK3] !== 1'b1) buck3_voltage_select_pin <= sel3_req;
  end
endmodule : host_pin_model

// ### test/pmic_default_sequencer_gpio_test.sv
`timescale 1ns/10ps
module pmic_default_sequencer_gpio_test;
  localparam int unsigned EXT = 50;
  localparam int unsigned RSTD = 80;
  localparam int unsigned RESTART = 100;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic input_lockout_release = 1'b0, input_below_warning = 1'b0;
  logic [4:0] rail_current_limit = 5'h00, rail_undervoltage = 5'h00, power_good;
  logic deep_sleep_request_pin, buck1_voltage_select_pin, buck3_voltage_select_pin;
  logic sleep_req = 1'b0, sel1_req = 1'b1, sel3_req = 1'b1;
  seq_pkg::rail_ctrl_s rail_ctrl;
  logic external_supply_enable, deep_sleep_mode, undervoltage_fault_state, irq;
  logic supply_warning_out_n_o, supply_warning_out_n_oe, interrupt_out_n_o;
  logic interrupt_out_n_oe, system_reset_out_n_o, system_reset_out_n_oe;
  int fail_count = 0, num_checks = 0, cycles = 0, n;
  logic [7:0] seed = 8'h3b;
  int order_q[$] = '{seq_pkg::R_LDO2, seq_pkg::R_BUCK2, seq_pkg::R_BUCK1, seq_pkg::R_BUCK3,
                     seq_pkg::R_LDO1};

  power_sequencer #(.EXT_DELAY_CYC(EXT), .RESET_DELAY_CYC(RSTD), .RESTART_DELAY_CYC(RESTART))
  power_sequencer_inst (
    .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .input_lockout_release, .input_below_warning, .rail_current_limit,
    .rail_undervoltage, .deep_sleep_request_pin, .buck1_voltage_select_pin,
    .buck3_voltage_select_pin, .rail_ctrl, .power_good, .external_supply_enable,
    .deep_sleep_mode, .undervoltage_fault_state, .irq, .supply_warning_out_n_o,
    .supply_warning_out_n_oe, .interrupt_out_n_o, .interrupt_out_n_oe, .system_reset_out_n_o,
    .system_reset_out_n_oe);

  host_pin_model host_pin_model_inst (
    .aclk, .aresetn, .sleep_req, .sel1_req, .sel3_req, .rail_enable(rail_ctrl.enable),
    .deep_sleep_request_pin, .buck1_voltage_select_pin, .buck3_voltage_select_pin);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task wr(input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : wr

  task rd_reg(input logic [7:0] a);
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd_reg

  // Follows the rails from the given step of the order to a released reset pin.
  task ramp(input int first);
    logic [4:0] exp;
    exp = 5'h00;
    for (int k = 0; k < first; k++) exp[order_q[k]] = 1'b1;
    for (int k = first; k < 5; k++) begin
      n = 0;
      while (!rail_ctrl.enable[order_q[k]] && n < 6000) begin
        @(posedge aclk);
        n++;
      end
      exp[order_q[k]] = 1'b1;
      chk(rail_ctrl.enable, exp);
      if (k > first) chk(n >= seq_pkg::START_DELAY_CYC, 32'h1);
    end
    n = 0;
    while ((!external_supply_enable || system_reset_out_n_oe) && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    chk(external_supply_enable, 32'h1);
    chk(system_reset_out_n_oe, 32'h0);
    chk(power_good, 5'h1f);
  endtask : ramp

  initial forever #5 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      $display("timeout at %0t", $time);
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    chk(system_reset_out_n_oe, 32'h1);
    aresetn <= 1'b1;
    rd_reg(seq_pkg::ADDR_ID);
    chk(rd, seq_pkg::ID_VALUE);
    rd_reg(seq_pkg::ADDR_MASK);
    chk(rd, {28'h0, seq_pkg::MASK_RESET});
    rd_reg(8'h20);
    chk(rsp, seq_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h24, 32'h1);
    chk(rsp, seq_pkg::RESP_SLVERR);
    $display("test registers done");
    seed = lfsr(seed);
    sel1_req <= seed[0];
    sel3_req <= seed[1];
    input_lockout_release <= 1'b1;
    ramp(0);
    chk(rail_ctrl.buck1_alternate, !sel1_req);
    chk(rail_ctrl.buck3_alternate, !sel3_req);
    chk(irq, 32'h1);
    rd_reg(seq_pkg::ADDR_STATE);
    chk(rd, 32'h3f2);
    rd_reg(seq_pkg::ADDR_STATUS);
    chk(rd, 32'h2);
    rd_reg(seq_pkg::ADDR_STATUS);
    chk(rd, 32'h0);
    chk(irq, 32'h0);
    $display("test power up done");
    wr(seq_pkg::ADDR_MASK, 32'h0);
    input_below_warning <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({supply_warning_out_n_oe, irq}, 32'h2);
    wr(seq_pkg::ADDR_MASK, 32'hf);
    repeat (2) @(posedge aclk);
    chk({irq, interrupt_out_n_oe}, 32'h3);
    rd_reg(seq_pkg::ADDR_STATUS);
    chk(rd, 32'h8);
    input_below_warning <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({supply_warning_out_n_oe, irq}, 32'h0);
    $display("test warning done");
    sleep_req <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({deep_sleep_mode, rail_ctrl.buck2_alternate, rail_ctrl.enable}, 32'h63);
    chk(external_supply_enable, 32'h0);
    rd_reg(seq_pkg::ADDR_STATE);
    chk(rd, 32'h033);
    rd_reg(seq_pkg::ADDR_STATUS);
    chk(rd, 32'h4);
    seed = lfsr(seed);
    sel1_req <= seed[0];
    sel3_req <= seed[1];
    sleep_req <= 1'b0;
    ramp(2);
    chk({deep_sleep_mode, rail_ctrl.buck2_alternate}, 32'h0);
    chk(rail_ctrl.buck1_alternate, !sel1_req);
    chk(rail_ctrl.buck3_alternate, !sel3_req);
    $display("test deep sleep done");
    rail_current_limit[seq_pkg::R_BUCK1] <= 1'b1;
    rail_undervoltage[seq_pkg::R_BUCK1] <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({undervoltage_fault_state, interrupt_out_n_oe, rail_ctrl.enable}, 32'h60);
    chk({external_supply_enable, power_good}, 32'h0);
    rail_current_limit <= 5'h00;
    rail_undervoltage <= 5'h00;
    n = 0;
    while (!rail_ctrl.enable[seq_pkg::R_LDO2] && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    chk(n >= RESTART, 32'h1);
    chk(rail_ctrl.enable, 5'h01);
    rd_reg(seq_pkg::ADDR_STATUS);
    chk(rd & 32'h1, 32'h1);
    $display("test fault done");
    test_done();
  end
endmodule : pmic_default_sequencer_gpio_test
